/* hw/mdu_consts.svh */
// constants of the multiply/divide unit: offsets, fields, reset values, counts
// Function
// RULE1 - 8-bit control at FF68, reset 00
// RULE2 - start bit launches, self-clears when done
// RULE3 - mode bit: 0 divide, 1 multiply
// RULE4 - clearing start while busy aborts
// RULE5 - completion beats simultaneous clear, flags interrupt
// RULE6 - software keeps mode steady while busy
// RULE7 - multiply finishes after 16 clocks
// RULE8 - divide finishes after 32 clocks
// RULE9 - intermediate values land in result registers
// RULE10 - product lands across both operand halves
// RULE11 - quotient in operand register, remainder separate
// RULE12 - interrupt request follows start bit clearing
// RULE13 - software loads A low, B, writes 81
// RULE14 - software loads dividend, divisor, writes 80
// RULE15 - after abort software reloads all registers
// RULE16 - multiply low halves, clear high at start
// RULE17 - remainder cleared at start; reset zeroes registers
// RULE18 - software never divides by zero
// RULE19 - interrupt priority 24, vector 0034
// RULE20 - all operands unsigned
// RULE21 - operands taken at start, result after last; the code reads operand b (divisor_multiplier_reg) live at every step
`ifndef MDU_CONSTS_SVH
`define MDU_CONSTS_SVH

// ==========================================================
// register addresses (byte wide bus)
`define MDU_ADDR_REM_LO 16'hFF60
`define MDU_ADDR_REM_HI 16'hFF61
`define MDU_ADDR_OPR_B0 16'hFF62
`define MDU_ADDR_OPR_B1 16'hFF63
`define MDU_ADDR_OPR_B2 16'hFF64
`define MDU_ADDR_OPR_B3 16'hFF65
`define MDU_ADDR_DVS_LO 16'hFF66
`define MDU_ADDR_DVS_HI 16'hFF67
`define MDU_ADDR_CTRL 16'hFF68

// ==========================================================
// control register fields and reset values
`define MDU_CTRL_START_BIT 7
`define MDU_CTRL_MODE_BIT 0
`define MDU_CTRL_RESET 8'h00
`define MDU_WORD16_RESET 16'h0000

// ==========================================================
// iteration counts and interrupt attributes
`define MDU_MUL_STEPS 16
`define MDU_DIV_STEPS 32
`define MDU_IRQ_PRIORITY 24
`define MDU_IRQ_VECTOR 16'h0034

`endif

/* hw/mdu_pkg.sv */
// types shared by the multiply/divide unit
package mdu_pkg;

  // ==========================================================
  // operation mode as held in the control register
  typedef enum logic {
    MDU_DIV = 1'b0,
    MDU_MUL = 1'b1
  } mdu_mode_e;

  // ==========================================================
  // sequencer states, gray coded idle -> run -> done
  typedef enum logic [1:0] {
    MDU_IDLE = 2'b00,
    MDU_RUN = 2'b01,
    MDU_DONE = 2'b11
  } mdu_state_e;

  // ==========================================================
  // working registers of the datapath
  typedef struct packed {
    logic [15:0] hi;  // operand/result high half
    logic [15:0] lo;  // operand/result low half
    logic [15:0] rem; // remainder
  } mdu_work_s;

endpackage

/* hw/mdu_step.sv */
// one iteration of shift-add multiply or restoring divide
`timescale 1ns/1ps
`default_nettype none
module mdu_step
  import mdu_pkg::*;
(
  input wire mdu_mode_e mode,
  input wire mdu_work_s cur,
  input wire logic [15:0] operand_b,
  output mdu_work_s nxt
);

  logic [16:0] sum;   // multiply partial sum with carry
  logic [16:0] trial; // divide shifted remainder
  logic [16:0] diff;  // divide trial subtraction

  // ==========================================================
  // combinational step, unsigned throughout
  always_comb begin
    sum = {1'b0, cur.hi} + (cur.lo[0] ? {1'b0, operand_b} : 17'h00000); // RULE20
    trial = {cur.rem, cur.hi[15]};
    diff = trial - {1'b0, operand_b};
    nxt = cur;
    if (mode == MDU_MUL) begin
      // add then shift product right, remainder untouched
      nxt.hi = sum[16:1];            // RULE16
      nxt.lo = {sum[0], cur.lo[15:1]};
    end else begin
      // shift dividend left into remainder, subtract if it fits
      nxt.hi = {cur.hi[14:0], cur.lo[15]};
      if (trial >= {1'b0, operand_b}) begin
        nxt.rem = diff[15:0];
        nxt.lo = {cur.lo[14:0], 1'b1};
      end else begin
        nxt.rem = trial[15:0];
        nxt.lo = {cur.lo[14:0], 1'b0};
      end
    end
  end

endmodule // mdu_step
`default_nettype wire

/* hw/mdu_top.sv */
// memory-mapped multiply/divide unit with byte register bus
`timescale 1ns/1ps
`default_nettype none
`include "mdu_consts.svh"
module mdu_top
  import mdu_pkg::*;
#(
  parameter int MUL_STEPS = `MDU_MUL_STEPS, // multiply iterations
  parameter int DIV_STEPS = `MDU_DIV_STEPS  // divide iterations
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic muldiv_done_irq
);

  // ==========================================================
  // interrupt attributes for the controller outside
  localparam int IRQ_PRIORITY = `MDU_IRQ_PRIORITY; // RULE19
  localparam logic [15:0] IRQ_VECTOR = `MDU_IRQ_VECTOR; // RULE19

  // ==========================================================
  // state
  mdu_state_e state;       // sequencer state
  mdu_state_e next_state;
  logic [5:0] count;       // steps still to run after the current one
  logic [5:0] next_count;
  mdu_mode_e mode_select_bit;  // mode bit of the control register
  mdu_mode_e next_mode_select_bit;
  mdu_work_s work;         // operand/result and remainder registers
  mdu_work_s next_work;
  logic [15:0] divisor_multiplier_reg; // operand b
  logic [15:0] next_divisor_multiplier_reg;
  logic [7:0] next_bus_rdata;
  logic next_done_irq;

  // ==========================================================
  // decoded accesses
  logic ctrl_wr;        // write to the control register
  logic start_req;      // write with start bit set
  logic stop_req;       // write with start bit clear
  logic start_busy_bit; // start/busy as read back
  mdu_work_s step_out;  // one datapath iteration
  logic [7:0] ctrl_value;

  assign ctrl_wr = bus_wr && (bus_addr == `MDU_ADDR_CTRL);
  assign start_req = ctrl_wr && bus_wdata[`MDU_CTRL_START_BIT];
  assign stop_req = ctrl_wr && !bus_wdata[`MDU_CTRL_START_BIT];
  // busy while running and in the finishing cycle
  assign start_busy_bit = (state != MDU_IDLE); // RULE2
  // unused bits read zero
  assign ctrl_value = {start_busy_bit, 6'h00, mode_select_bit}; // RULE1

  // ==========================================================
  // byte merge into a 16-bit register half
  function automatic logic [15:0] put_byte(input logic [15:0] val,
                                           input logic upper,
                                           input logic [7:0] data);
    logic [15:0] res;
    res = val;
    if (upper) begin
      res[15:8] = data;
    end else begin
      res[7:0] = data;
    end
    return res;
  endfunction

  // ==========================================================
  // iteration datapath
  mdu_step u_step (
    .mode(mode_select_bit),
    .cur(work),
    .operand_b(divisor_multiplier_reg),
    .nxt(step_out)
  );

  // ==========================================================
  // sequencer and register writes, next values
  always_comb begin
    next_state = state;
    next_count = count;
    next_mode_select_bit = mode_select_bit;
    next_work = work;
    next_divisor_multiplier_reg = divisor_multiplier_reg;
    next_done_irq = 1'b0;
    // mode bit follows every control write
    if (ctrl_wr) begin
      next_mode_select_bit = mdu_mode_e'(bus_wdata[`MDU_CTRL_MODE_BIT]); // RULE3
    end
    // operand b is writable at any time; changing it mid-run spoils the result
    if (bus_wr && bus_addr == `MDU_ADDR_DVS_LO) begin
      next_divisor_multiplier_reg = put_byte(divisor_multiplier_reg, 1'b0, bus_wdata);
    end
    if (bus_wr && bus_addr == `MDU_ADDR_DVS_HI) begin
      next_divisor_multiplier_reg = put_byte(divisor_multiplier_reg, 1'b1, bus_wdata);
    end
    case (state)
      MDU_IDLE: begin
        // operand register writable only while idle
        if (bus_wr && bus_addr == `MDU_ADDR_OPR_B0) begin
          next_work.lo = put_byte(work.lo, 1'b0, bus_wdata);
        end
        if (bus_wr && bus_addr == `MDU_ADDR_OPR_B1) begin
          next_work.lo = put_byte(work.lo, 1'b1, bus_wdata);
        end
        if (bus_wr && bus_addr == `MDU_ADDR_OPR_B2) begin
          next_work.hi = put_byte(work.hi, 1'b0, bus_wdata);
        end
        if (bus_wr && bus_addr == `MDU_ADDR_OPR_B3) begin
          next_work.hi = put_byte(work.hi, 1'b1, bus_wdata);
        end
        // launch: operands stand in the registers already
        if (start_req) begin // RULE2
          next_state = MDU_RUN; // RULE21
          next_work.rem = `MDU_WORD16_RESET; // RULE17
          if (bus_wdata[`MDU_CTRL_MODE_BIT]) begin
            next_work.hi = `MDU_WORD16_RESET; // RULE16
            next_count = 6'(MUL_STEPS - 1); // RULE7
          end else begin
            next_count = 6'(DIV_STEPS - 1); // RULE8
          end
        end
      end
      MDU_RUN: begin
        // partial values are visible in the registers
        next_work = step_out; // RULE9
        if (count == 6'h00) begin
          next_state = MDU_DONE;
        end else begin
          next_count = count - 6'h01;
        end
        // software stop abandons the run
        if (stop_req) begin
          next_state = MDU_IDLE; // RULE4
          next_count = 6'h00;
        end
      end
      MDU_DONE: begin
        // result already in place; a clear in this cycle does not cancel it
        next_state = MDU_IDLE; // RULE5
        next_done_irq = 1'b1; // RULE12
      end
      default: begin
        next_state = MDU_IDLE;
      end
    endcase
  end

  // ==========================================================
  // read data, registered one cycle after the strobe
  always_comb begin
    next_bus_rdata = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        `MDU_ADDR_REM_LO: next_bus_rdata = work.rem[7:0];   // RULE11
        `MDU_ADDR_REM_HI: next_bus_rdata = work.rem[15:8];
        `MDU_ADDR_OPR_B0: next_bus_rdata = work.lo[7:0];    // RULE10
        `MDU_ADDR_OPR_B1: next_bus_rdata = work.lo[15:8];
        `MDU_ADDR_OPR_B2: next_bus_rdata = work.hi[7:0];
        `MDU_ADDR_OPR_B3: next_bus_rdata = work.hi[15:8];
        `MDU_ADDR_DVS_LO: next_bus_rdata = divisor_multiplier_reg[7:0];
        `MDU_ADDR_DVS_HI: next_bus_rdata = divisor_multiplier_reg[15:8];
        `MDU_ADDR_CTRL: next_bus_rdata = ctrl_value;
        default: next_bus_rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= MDU_IDLE;
      count <= 6'h00;
      mode_select_bit <= MDU_DIV; // RULE1
      work <= '0; // RULE17
      divisor_multiplier_reg <= `MDU_WORD16_RESET;
      bus_rdata <= 8'h00;
      muldiv_done_irq <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      mode_select_bit <= next_mode_select_bit;
      work <= next_work;
      divisor_multiplier_reg <= next_divisor_multiplier_reg;
      bus_rdata <= next_bus_rdata;
      muldiv_done_irq <= next_done_irq;
    end
  end

endmodule // mdu_top
`default_nettype wire

/* verification/mdu_top_assertions.sv */
// checker: timing and readback properties of the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
module mdu_chk #(
  parameter int MUL_STEPS = 16, // multiply steps
  parameter int DIV_STEPS = 32  // divide steps
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic muldiv_done_irq
);
  // ==========================================================
  // shadow of the run state
  logic run; // operation in progress
  logic md; // mode taken at start
  logic [7:0] cnt; // cycles since start
  logic cw; // control write
  logic rc; // control read
  logic stp; // still in the step phase
  int n; // step count of the mode
  assign cw = bus_wr && bus_addr == 16'hFF68;
  assign rc = bus_rd && bus_addr == 16'hFF68;
  assign n = md ? MUL_STEPS : DIV_STEPS;
  assign stp = run && cnt < n;
  // track start, abort and completion
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run <= 1'b0;
      md <= 1'b0;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
      // a start in the cycle of the completion pulse begins a new run
      if (cw && bus_wdata[7] && (!run || muldiv_done_irq)) begin
        run <= 1'b1;
        md <= bus_wdata[0];
        cnt <= 8'h00;
      end else if ((cw && !bus_wdata[7] && stp) || muldiv_done_irq) begin
        run <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // properties
  property p_rd_idle; !bus_rd |=> bus_rdata == 8'h00; endproperty
  property p_ctrl_rsv; rc |=> bus_rdata[6:1] == 6'h00; endproperty
  property p_unmap;
    bus_rd && (bus_addr < 16'hFF60 || bus_addr > 16'hFF68) |=> bus_rdata == 8'h00;
  endproperty
  property p_irq_cause; muldiv_done_irq |-> run && cnt == n + 1; endproperty
  property p_irq_pulse; $rose(muldiv_done_irq) |=> !muldiv_done_irq; endproperty
  property p_busy_rd; rc && stp |=> bus_rdata[7]; endproperty
  property p_idle_rd; rc && !run |=> !bus_rdata[7]; endproperty
  property p_abort; cw && !bus_wdata[7] && stp |=> !muldiv_done_irq [*4]; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved bits set");
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  a_irq_cause: assert property (p_irq_cause) else $error("irq timing");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  a_busy_rd: assert property (p_busy_rd) else $error("busy not seen");
  a_idle_rd: assert property (p_idle_rd) else $error("busy when idle");
  a_abort: assert property (p_abort) else $error("irq after abort");
  // main scenarios
  c_mul: cover property (muldiv_done_irq && md);
  c_div: cover property (muldiv_done_irq && !md);
  c_abort: cover property (cw && !bus_wdata[7] && stp);
endmodule // mdu_chk
bind mdu_top mdu_chk #(.MUL_STEPS(MUL_STEPS), .DIV_STEPS(DIV_STEPS)) u_mdu_chk (
  .clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .muldiv_done_irq(muldiv_done_irq));
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench of the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
`include "mdu_consts.svh"
module tb_top;
  // ==========================================================
  // drive, observe, counters
  typedef struct packed {
    logic [31:0] a; // dividend or multiplier a
    logic [15:0] b; // divisor or multiplier b
    logic m; // mode bit
    logic [31:0] q; // expected quotient/product
    logic [15:0] r; // expected remainder
  } mdu_row_s;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata;
  logic muldiv_done_irq;
  logic [7:0] d;
  int errors = 0;
  int tests_run = 0;
  // every divide row keeps a nonzero divisor
  mdu_row_s rows [6] = '{
    '{32'hDCBA2586, 16'h0018, 1'b0, 32'h09326C3A, 16'h0016},
    '{32'hABCD0003, 16'h0002, 1'b1, 32'h00000006, 16'h0000},
    '{32'h000000DA, 16'h0093, 1'b1, 32'h00007D2E, 16'h0000},
    '{32'h0000FFFF, 16'hFFFF, 1'b1, 32'hFFFE0001, 16'h0000},
    '{32'h00000005, 16'h0007, 1'b0, 32'h00000000, 16'h0005},
    '{32'hFFFFFFFF, 16'hFFFF, 1'b0, 32'h00010001, 16'h0000}};
  mdu_top u_mdu_top (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .muldiv_done_irq(muldiv_done_irq));
  initial begin
    forever #25 clk = ~clk;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    #5 bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    @(posedge clk);
    #5 bus_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    #5 bus_addr = a;
    bus_rd = 1'b1;
    @(posedge clk);
    #5 bus_rd = 1'b0;
    v = bus_rdata;
  endtask
  // load operands and start
  task automatic ld(input mdu_row_s r);
    for (int i = 0; i < 4; i++) wr(16'hFF62 + 16'(i), r.a[8*i +: 8]);
    wr(16'hFF66, r.b[7:0]);
    wr(16'hFF67, r.b[15:8]);
    wr(16'hFF68, {1'b1, 6'h00, r.m});
  endtask
  // read back both results
  task automatic res(input mdu_row_s r);
    logic [31:0] q;
    logic [15:0] s;
    for (int i = 0; i < 4; i++) rd(16'hFF62 + 16'(i), q[8*i +: 8]);
    rd(16'hFF60, s[7:0]);
    rd(16'hFF61, s[15:8]);
    chk(q, r.q);
    chk({16'h0000, s}, {16'h0000, r.r});
  endtask
  task automatic conclude();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #3000000;
    errors++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin
    int n;
    repeat (8) @(posedge clk);
    #5 rst_b = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(16'hFF60 + 16'(i), d);
      chk({24'h0, d}, 32'h0);
    end
    foreach (rows[k]) begin
      ld(rows[k]);
      n = 0;
      while (muldiv_done_irq !== 1'b1 && n < 40) begin
        @(posedge clk);
        #1 n++;
      end
      chk(32'(n), rows[k].m ? `MDU_MUL_STEPS + 1 : `MDU_DIV_STEPS + 1);
      rd(16'hFF68, d);
      chk({24'h0, d}, {31'h0, rows[k].m});
      res(rows[k]);
    end
    wr(16'hFF69, 8'h55);
    rd(16'hFF69, d);
    chk({24'h0, d}, 32'h0);
    wr(16'hFF68, 8'h7F);
    rd(16'hFF68, d);
    chk({24'h0, d}, 32'h01);
    wr(16'hFF68, 8'h80);
    rd(16'hFF68, d);
    chk({24'h0, d}, 32'h80);
    wr(16'hFF68, 8'h00);
    rd(16'hFF68, d);
    chk({24'h0, d}, 32'h00);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1 n += (muldiv_done_irq === 1'b1);
    end
    chk(32'(n), 32'h0);
    ld(rows[2]);
    repeat (`MDU_MUL_STEPS - 1) @(posedge clk);
    wr(16'hFF68, 8'h01);
    chk({31'h0, muldiv_done_irq}, 32'h1);
    res(rows[2]);
    // reset in mid-run: everything back to zero, no completion pulse
    ld(rows[0]);
    repeat (4) @(posedge clk);
    #5 rst_b = 1'b0;
    @(posedge clk);
    #5 rst_b = 1'b1;
    chk({31'h0, muldiv_done_irq}, 32'h0);
    for (int i = 0; i < 9; i++) begin
      rd(16'hFF60 + 16'(i), d);
      chk({24'h0, d}, 32'h0);
    end
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1 n += (muldiv_done_irq === 1'b1);
    end
    chk(32'(n), 32'h0);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
